// ---- logic/aas_pkg.sv ----
package aas_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_DATA   = 8'h0c;
  localparam logic [7:0] A_IVAL   = 8'h10;
  localparam logic [7:0] A_CNT    = 8'h14;
  localparam logic [7:0] A_TBASE  = 8'h18;
  localparam logic [7:0] A_DIV    = 8'h1c;
  localparam logic [7:0] A_CGADR  = 8'h20;
  localparam logic [7:0] A_CGDAT  = 8'h24;
  localparam logic [7:0] A_CALADR = 8'h28;
  localparam logic [7:0] A_CALDAT = 8'h2c;
  localparam logic [7:0] A_GAP    = 8'h30;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int C_TWOS  = 0;
  localparam int C_SCAN  = 1;
  localparam int C_INTV  = 2;
  localparam int C_PRE   = 3;
  localparam int C_C32   = 4;
  localparam int C_EXTC  = 5;
  localparam int C_TRIG2 = 6;
  localparam int C_EXTTB = 7;
  localparam int C_STSRC = 8;
  localparam int C_CVSRC = 9;
  localparam int C_GTSRC = 10;
  localparam int C_GATE  = 11;
  localparam int CTRL_W  = 12;
  localparam int K_START = 0;
  localparam int K_CONV  = 1;
  localparam int K_FCLR  = 2;
  localparam int K_OCLR  = 3;
  localparam int K_STOP  = 4;
  localparam int K_TRIG  = 5;
  localparam int E_SYNC  = 7;
  localparam int E_LAST  = 8;
  localparam int E_END   = 9;
  localparam int P_CONV  = 0;
  localparam int P_TRIG  = 1;
  localparam int P_BUS   = 2;
  localparam int P_GATE  = 5;
  localparam int P_TB    = 6;
  localparam int P_N     = 7;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int CG_W     = 10;
  localparam int CG_DEPTH = 512;
  localparam int CAL_DEPTH = 64;
  localparam logic [5:0] CAL_PROT_LO = 6'd52;
  localparam int ADC_W    = 12;
  localparam int F_W      = 16;
  localparam int F_DEPTH  = 256;
  localparam logic [8:0] F_HALF = 9'd128;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [15:0] R16_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACQ  = 3'b010,
    ST_GAP  = 3'b100
  } aas_state_e;

endpackage

// ---- logic/aas_fifo.sv ----
`timescale 1ns/1ps
module aas_fifo
  import aas_pkg::*;
(
  // Clock and reset
  input  wire logic           hclk,
  input  wire logic           hresetn,
  // Fill side
  input  wire logic           push,
  input  wire logic [F_W-1:0] push_data,
  // Drain side
  input  wire logic           pop,
  input  wire logic           clear,
  output logic      [F_W-1:0] pop_data,
  output logic      [8:0]     level,
  output logic                full
);

  typedef struct packed {
    logic [7:0] wp;
    logic [7:0] rp;
    logic [8:0] cnt;
  } aas_fifo_s;

  aas_fifo_s r, n;
  logic [F_W-1:0] mem [F_DEPTH];
  logic do_push;
  logic do_pop;

  // A push into a full buffer is dropped here; the parent flags the loss.
  assign full     = r.cnt == 9'(F_DEPTH);
  assign do_push  = push && !full;
  assign do_pop   = pop && r.cnt != 9'h000;
  assign pop_data = mem[r.rp];
  assign level    = r.cnt;

  always_comb begin
    n = r;
    if (do_push) begin
      n.wp = r.wp + 8'h01;
    end
    if (do_pop) begin
      n.rp = r.rp + 8'h01;
    end
    n.cnt = r.cnt + {8'h00, do_push} - {8'h00, do_pop};
    if (clear) begin
      n = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[r.wp] <= push_data;
    end
  end

  fifo_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_pop && !clear |=> r.rp == $past(r.rp) + 8'h01)
    else $error("fifo read pointer did not advance");

endmodule

// ---- logic/aas_seq.sv ----
`timescale 1ns/1ps
// Functional notes
// - Calibration words 52..63 refuse writes
// - Entry drives four channel, three gain bits
// - Converter result is a 12-bit word
// - Finished result goes into 16x256 FIFO
// - Push into full FIFO sets overflow
// - Not-empty flag when any result held
// - Half-full flag at 128 words held
// - Binary mode zeroes bits 15..12
// - Two's complement copies bit 11 upward
// - Pretrigger: acquire, count after second trigger
// - Continuous scan wraps to entry zero
// - Interval scan waits between sequences
// - Single convert by pin or software
// - External convert stream replaces interval timer
// - 16-bit interval down counter, reload, pulse
// - Selectable timebases set interval span
// - Sample counter 16 or 32 bits
// - Count each timer-paced convert, stop at zero
// - Software or trigger pin starts both counters
// - Optionally wait second trigger falling edge
// - Start, convert, gate sources selectable
// - 512 entries with last-of-sequence bit
// - Pointer steps every N conversions or never
// - Scan pulse at each conversion start
module aas_seq
  import aas_pkg::*;
(
  // AHB-Lite slave
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Converter
  output logic                  adc_start_n,
  input  wire logic             adc_done,
  input  wire logic [ADC_W-1:0] adc_data,
  output logic      [3:0]       mux_chan,
  output logic      [2:0]       amp_gain,
  // Connector and sync bus
  input  wire logic             ext_convert_in_n,
  input  wire logic             ext_trigger_in_n,
  input  wire logic             ext_gate_in,
  input  wire logic             ext_timebase,
  input  wire logic [2:0]       board_sync_bus,
  output logic                  conversion_scan_pulse,
  output logic                  channel_pointer_step,
  // Request lines
  output logic                  fifo_not_empty,
  output logic                  fifo_half_full
);

  typedef struct packed {
    aas_state_e        st;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       ival;
    logic [15:0]       itv;
    logic [15:0]       tbase;
    logic [15:0]       tb_cnt;
    logic [15:0]       div;
    logic [15:0]       div_cnt;
    logic [15:0]       gap;
    logic [15:0]       gap_cnt;
    logic [31:0]       cnt_ld;
    logic [31:0]       cnt;
    logic [8:0]        cg_adr;
    logic [8:0]        ptr;
    logic [5:0]        cal_adr;
    logic              pre;
    logic              ovf;
    logic [P_N-1:0]    s1;
    logic [P_N-1:0]    s2;
    logic [P_N-1:0]    s3;
    logic              pend;
    logic              wr;
    logic [7:0]        adr;
    logic              hready;
    logic [31:0]       hrdata;
    logic              hresp;
    logic [3:0]        chan;
    logic [2:0]        gain;
    logic              start_n;
    logic              scan;
    logic              step;
    logic              ne;
    logic              hf;
  } aas_regs_s;

  aas_regs_s r, n;
  logic [CG_W-1:0] cg_mem  [CG_DEPTH];
  logic [7:0]      cal_mem [CAL_DEPTH];

  logic [P_N-1:0] pins, fall, rise;
  logic [F_W-1:0] push_data, pop_data;
  logic [8:0]     f_lvl;
  logic           f_full;
  logic [CG_W-1:0] entry;
  logic [5:0]     cmd;
  logic           wr_now, rd_now, acc, pop, cg_we, cal_we;
  logic           trig_e, conv_e, gate_ok, tb_tick, acq, timer_fire, gap_end;
  logic           conv, run_conv, step_now, counting, last_sample, trig2;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  assign pins = {ext_timebase, ext_gate_in, board_sync_bus, ext_trigger_in_n,
                 ext_convert_in_n};
  assign fall = r.s3 & ~r.s2;
  assign rise = r.s2 & ~r.s3;

  // Sync bus lines carry the same active-low pulses as the connector pins.
  assign trig_e  = r.ctrl[C_STSRC] ? fall[P_BUS] : fall[P_TRIG];
  assign conv_e  = r.ctrl[C_CVSRC] ? fall[P_BUS+1] : fall[P_CONV];
  assign gate_ok = !r.ctrl[C_GATE] ||
                   (r.ctrl[C_GTSRC] ? r.s2[P_BUS+2] : r.s2[P_GATE]);
  assign tb_tick = r.ctrl[C_EXTTB] ? rise[P_TB] : (r.tb_cnt == 16'h0000);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign acc    = hsel && htrans[1] && hready;
  assign wr_now = r.pend && r.wr;
  assign rd_now = r.pend && !r.wr;
  assign cmd    = (wr_now && r.adr == A_CMD) ? hwdata[5:0] : 6'h00;
  assign pop    = rd_now && r.adr == A_DATA;
  assign cg_we  = wr_now && r.adr == A_CGDAT;
  assign cal_we = wr_now && r.adr == A_CALDAT && r.cal_adr < CAL_PROT_LO;

  // ****************************************************************
  // Acquisition events
  // ****************************************************************
  assign entry      = cg_mem[r.ptr];
  assign acq        = r.st == ST_ACQ;
  assign timer_fire = acq && !r.ctrl[C_EXTC] && gate_ok && tb_tick &&
                      r.itv == 16'h0000;
  assign gap_end    = r.st == ST_GAP && gate_ok && tb_tick &&
                      r.gap_cnt == 16'h0000;
  assign conv       = timer_fire || gap_end ||
                      (acq && r.ctrl[C_EXTC] && conv_e && gate_ok) ||
                      (r.st == ST_IDLE && (conv_e || cmd[K_CONV]));
  assign run_conv   = conv && r.st != ST_IDLE;
  assign step_now   = run_conv && r.ctrl[C_SCAN] && r.div_cnt == 16'h0000;
  assign counting   = run_conv && !r.pre && !r.ctrl[C_EXTC];
  assign last_sample = counting && (r.ctrl[C_C32] ? r.cnt == 32'h1 :
                                    r.cnt[15:0] == 16'h0001);
  assign trig2      = trig_e || (cmd[K_TRIG] && !r.ctrl[C_TRIG2]);
  assign push_data  = {r.ctrl[C_TWOS] ? {4{adc_data[ADC_W-1]}} : 4'h0,
                       adc_data};

  aas_fifo u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .push      (adc_done),
    .push_data (push_data),
    .pop       (pop),
    .clear     (cmd[K_FCLR]),
    .pop_data  (pop_data),
    .level     (f_lvl),
    .full      (f_full)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] rd;
    rd = 32'h0;
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.tb_cnt = (r.tb_cnt == 16'h0000) ? r.tbase : r.tb_cnt - 16'h0001;
    if (acq && !r.ctrl[C_EXTC] && gate_ok && tb_tick) begin
      n.itv = (r.itv == 16'h0000) ? r.ival : r.itv - 16'h0001;
    end
    if (r.st == ST_GAP && gate_ok && tb_tick) begin
      n.gap_cnt = r.gap_cnt - 16'h0001;
    end
    if (gap_end) begin
      n.st  = ST_ACQ;
      n.itv = r.ival;
    end
    if (run_conv && r.ctrl[C_SCAN]) begin
      if (r.div_cnt != 16'h0000) begin
        n.div_cnt = r.div_cnt - 16'h0001;
      end else begin
        n.div_cnt = r.div;
        if (!r.ctrl[C_INTV]) begin
          n.ptr = entry[E_LAST] ? 9'h000 : r.ptr + 9'h001;
        end else begin
          n.ptr = entry[E_END] ? 9'h000 : r.ptr + 9'h001;
          if (entry[E_LAST]) begin
            n.st      = ST_GAP;
            n.gap_cnt = r.gap;
          end
        end
      end
    end
    if (counting) begin
      n.cnt = r.cnt - 32'h1;
    end
    if (last_sample) begin
      n.st = ST_IDLE;
    end
    if (r.pre && r.st != ST_IDLE && trig2) begin
      n.pre = 1'b0;
    end
    if (r.st == ST_IDLE && (cmd[K_START] || trig_e)) begin
      n.st      = ST_ACQ;
      n.pre     = r.ctrl[C_PRE] || r.ctrl[C_TRIG2];
      n.cnt     = r.ctrl[C_C32] ? r.cnt_ld : {16'h0000, r.cnt_ld[15:0]};
      n.itv     = r.ival;
      n.ptr     = 9'h000;
      n.div_cnt = r.div;
      n.tb_cnt  = r.tbase;
    end
    if (cmd[K_STOP]) begin
      n.st  = ST_IDLE;
      n.pre = 1'b0;
    end
    if (cmd[K_OCLR]) begin
      n.ovf = 1'b0;
    end
    if (adc_done && f_full) begin
      n.ovf = 1'b1;
    end
    n.start_n = !conv;
    n.scan    = conv;
    n.step    = step_now;
    n.chan    = entry[3:0];
    n.gain    = entry[6:4];
    n.ne      = f_lvl != 9'h000;
    n.hf      = f_lvl >= F_HALF;
    case (r.adr)
      A_CTRL:   rd = {20'h0, r.ctrl};
      A_STAT:   rd = {26'h0, r.st == ST_GAP, r.pre, r.st != ST_IDLE, r.ovf, r.hf, r.ne};
      A_DATA:   rd = {16'h0, pop_data};
      A_IVAL:   rd = {16'h0, r.ival};
      A_CNT:    rd = r.cnt;
      A_TBASE:  rd = {16'h0, r.tbase};
      A_DIV:    rd = {16'h0, r.div};
      A_CGADR:  rd = {23'h0, r.cg_adr};
      A_CGDAT:  rd = {22'h0, cg_mem[r.cg_adr]};
      A_CALADR: rd = {26'h0, r.cal_adr};
      A_CALDAT: rd = {24'h0, cal_mem[r.cal_adr]};
      A_GAP:    rd = {16'h0, r.gap};
      default:  rd = 32'h0;
    endcase
    if (r.pend) begin
      n.pend   = 1'b0;
      n.hready = 1'b1;
      if (!r.wr) begin
        n.hrdata = rd;
      end else begin
        case (r.adr)
          A_CTRL:   n.ctrl    = hwdata[CTRL_W-1:0];
          A_IVAL:   n.ival    = hwdata[15:0];
          A_CNT:    n.cnt_ld  = hwdata;
          A_TBASE:  n.tbase   = hwdata[15:0];
          A_DIV:    n.div     = hwdata[15:0];
          A_CGADR:  n.cg_adr  = hwdata[8:0];
          A_CGDAT:  n.cg_adr  = r.cg_adr + 9'h001;
          A_CALADR: n.cal_adr = hwdata[5:0];
          A_GAP:    n.gap     = hwdata[15:0];
          default:  n.hresp   = 1'b0;
        endcase
      end
    end
    if (acc) begin
      n.pend   = 1'b1;
      n.wr     = hwrite;
      n.adr    = haddr[7:0];
      n.hready = 1'b0;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.ctrl    <= CTRL_RST;
      r.ival    <= R16_RST;
      r.hready  <= 1'b1;
      r.start_n <= 1'b1;
      r.s1      <= '1;
      r.s2      <= '1;
      r.s3      <= '1;
    end else begin
      r <= n;
    end
  end

  // Memories carry no reset; software loads them before use.
  always_ff @(posedge hclk) begin
    if (cg_we) begin
      cg_mem[r.cg_adr] <= hwdata[CG_W-1:0];
    end
    if (cal_we) begin
      cal_mem[r.cal_adr] <= hwdata[7:0];
    end
  end

  assign hrdata                = r.hrdata;
  assign hreadyout             = r.hready;
  assign hresp                 = r.hresp;
  assign adc_start_n           = r.start_n;
  assign conversion_scan_pulse = r.scan;
  assign channel_pointer_step  = r.step;
  assign mux_chan              = r.chan;
  assign amp_gain              = r.gain;
  assign fifo_not_empty        = r.ne;
  assign fifo_half_full        = r.hf;

  // ****************************************************************
  // Checks
  // ****************************************************************
  cal_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_now && r.adr == A_CALDAT && r.cal_adr >= CAL_PROT_LO |=>
    cal_mem[$past(r.cal_adr)] === $past(cal_mem[r.cal_adr]))
    else $error("protected calibration word changed");
  ovf_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.ovf && !cmd[K_OCLR] |=> r.ovf)
    else $error("overflow dropped without clear");
  ovf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_done && f_full |=> r.ovf)
    else $error("overflow not raised");
  half_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fifo_half_full == ($past(f_lvl) >= F_HALF))
    else $error("half full flag wrong");
  ne_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 fifo_not_empty == ($past(f_lvl) != 9'h000))
    else $error("not empty flag wrong");
  scan_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 conversion_scan_pulse == $past(conv) && adc_start_n == !$past(conv))
    else $error("scan pulse not one cycle per convert");
  ptr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    run_conv && !r.ctrl[C_SCAN] |=> $stable(r.ptr))
    else $error("pointer moved in single channel");
  cont_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    step_now && !r.ctrl[C_INTV] && entry[E_LAST] && !cmd[K_START] |=>
    r.ptr == 9'h000 && r.st != ST_GAP)
    else $error("continuous scan did not wrap");
  gap_enter_a: assert property (@(posedge hclk) disable iff (!hresetn)
    step_now && r.ctrl[C_INTV] && entry[E_LAST] && !last_sample && !cmd[K_STOP] |=>
    r.st == ST_GAP)
    else $error("interval scan did not pause");
  count_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    last_sample && !cmd[K_START] |=> r.st == ST_IDLE)
    else $error("acquisition ran past its count");
  reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_fire && !gap_end && !cmd[K_STOP] |=> r.itv == $past(r.ival))
    else $error("interval counter did not reload");

endmodule

// ---- verification/aas_adc_model.sv ----
`timescale 1ns/1ps
module aas_adc_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Converter side
  input  wire logic        slow,
  input  wire logic        adc_start_n,
  input  wire logic [3:0]  mux_chan,
  input  wire logic [2:0]  amp_gain,
  output logic             adc_done,
  output logic [11:0]      adc_data
);
  // ****************************************************************
  // Pipelined converter
  // ****************************************************************
  // The result carries gain and channel, so the bench sees which entry fed
  // each conversion. Overlapping starts queue up, as a fast timer needs.
  logic [7:0]  pipe_q;
  logic [11:0] res_q [$];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pipe_q <= 8'h00;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
      res_q.delete();
    end else begin
      pipe_q <= {pipe_q[6:0], ~adc_start_n};
      adc_done <= 1'b0;
      // Outside a result the bus is released and keeps toggling.
      adc_data <= ~adc_data;
      if (!adc_start_n) begin
        res_q.push_back({amp_gain, mux_chan, 5'h05});
      end
      if (slow ? pipe_q[6] : pipe_q[0]) begin
        adc_done <= 1'b1;
        adc_data <= res_q.pop_front();
      end
    end
  end
endmodule

// ---- verification/aas_seq_tb.sv ----
`timescale 1ns/1ps
module aas_seq_tb
  import aas_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic        ext_convert_in_n = 1'b1;
  logic        ext_trigger_in_n = 1'b1;
  logic        slow = 1'b0;
  logic [2:0]  sync_bus = 3'h7;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, adc_start_n, adc_done;
  logic [11:0] adc_data;
  logic [3:0]  mux_chan;
  logic [2:0]  amp_gain;
  logic        conversion_scan_pulse, channel_pointer_step;
  logic        fifo_not_empty, fifo_half_full;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_scan = 0;
  int          n_step = 0;

  localparam logic [7:0]  RA [6] = '{A_IVAL, A_CNT, A_CMD, A_STAT, 8'h40, A_CTRL};
  localparam logic [31:0] RW [6] = '{32'h1234abcd, 32'h5, 32'h0, 32'hff, 32'hffffffff,
                                     32'hffffffff};
  localparam logic [31:0] RE [6] = '{32'habcd, 32'h0, 32'h0, 32'h0, 32'h0, 32'hfff};

  always #2.5 hclk = ~hclk;

  always @(posedge hclk) begin
    if (conversion_scan_pulse === 1'b1) n_scan++;
    if (channel_pointer_step === 1'b1) n_step++;
  end

  aas_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .adc_start_n(adc_start_n),
    .adc_done(adc_done), .adc_data(adc_data), .mux_chan(mux_chan), .amp_gain(amp_gain),
    .ext_convert_in_n(ext_convert_in_n), .ext_trigger_in_n(ext_trigger_in_n),
    .ext_gate_in(1'b1), .ext_timebase(1'b0), .board_sync_bus(sync_bus),
    .conversion_scan_pulse(conversion_scan_pulse),
    .channel_pointer_step(channel_pointer_step), .fifo_not_empty(fifo_not_empty),
    .fifo_half_full(fifo_half_full));

  aas_adc_model adc (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .adc_start_n(adc_start_n), .mux_chan(mux_chan), .amp_gain(amp_gain),
    .adc_done(adc_done), .adc_data(adc_data));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits for hready high at a rising edge; a hung slave ends the run.
  task wt;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        n_mismatch++;
        end_sim;
      end
      @(posedge hclk);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk(nm, v, e);
  endtask

  task drain(input int n);
    logic [31:0] v;
    for (int i = 0; i < n; i++) xfer(1'b0, A_DATA, 32'h0, v);
  endtask

  task pin(input logic trig);
    if (trig) ext_trigger_in_n <= 1'b0;
    else ext_convert_in_n <= 1'b0;
    repeat (3) @(posedge hclk);
    ext_trigger_in_n <= 1'b1;
    ext_convert_in_n <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  task idle;
    logic [31:0] s;
    for (int i = 0; i < 400; i++) begin
      xfer(1'b0, A_STAT, 32'h0, s);
      if (s[3] === 1'b0) return;
    end
    n_mismatch++;
    end_sim;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    logic [31:0] v;
    int          ns;
    int          np;
    int          pt [4];
    int          k;
    repeat (2) @(posedge hclk);
    chk("hreadyout", hreadyout, 32'h1);
    chk("hresp", hresp, 32'h0);
    chk("start_n", adc_start_n, 32'h1);
    chk("flags", {fifo_half_full, fifo_not_empty}, 32'h0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      wr(RA[i], RW[i]);
      rc("register", RA[i], RE[i]);
    end
    wr(A_CTRL, 32'h0);
    wr(A_CALADR, 32'h33);
    wr(A_CALDAT, 32'ha5);
    rc("cal 51", A_CALDAT, 32'ha5);
    wr(A_CALADR, 32'h34);
    wr(A_CALDAT, 32'h5a);
    xfer(1'b0, A_CALDAT, 32'h0, v);
    chk("cal 52", v === 32'h5a, 32'h0);
    wr(A_CGADR, 32'h0);
    wr(A_CGDAT, 32'h063);
    wr(A_CGDAT, 32'h315);
    wr(A_CGADR, 32'h1);
    rc("entry", A_CGDAT, 32'h315);
    wr(A_CTRL, 32'h1);
    wr(A_CMD, 32'h2);
    wr(A_CMD, 32'h2);
    repeat (20) @(posedge hclk);
    chk("not empty", fifo_not_empty, 32'h1);
    for (int i = 0; i < 2; i++) rc("twos", A_DATA, 32'hfc65);
    wr(A_CTRL, 32'h0);
    pin(1'b0);
    repeat (20) @(posedge hclk);
    rc("binary", A_DATA, 32'h0c65);
    repeat (3) @(posedge hclk);
    chk("empty", fifo_not_empty, 32'h0);
    slow <= 1'b1;
    wr(A_CTRL, 32'h2);
    wr(A_IVAL, 32'h1);
    wr(A_TBASE, 32'h0);
    wr(A_DIV, 32'h0);
    wr(A_CNT, 32'h4);
    ns = n_scan;
    np = n_step;
    wr(A_CMD, 32'h1);
    idle;
    repeat (12) @(posedge hclk);
    for (int i = 0; i < 4; i++) rc("scan", A_DATA, i[0] ? 32'h2a5 : 32'hc65);
    chk("scan pulses", n_scan - ns, 32'h4);
    chk("pointer steps", n_step - np, 32'h4);
    wr(A_CTRL, 32'h8);
    wr(A_IVAL, 32'h3);
    wr(A_CNT, 32'h2);
    pin(1'b1);
    repeat (40) @(posedge hclk);
    rc("frozen count", A_CNT, 32'h2);
    rc("pre state", A_STAT, 32'h19);
    pin(1'b1);
    idle;
    rc("count end", A_CNT, 32'h0);
    repeat (12) @(posedge hclk);
    wr(A_CMD, 32'h4);
    wr(A_CTRL, 32'h20);
    wr(A_CMD, 32'h1);
    for (int i = 0; i < 3; i++) pin(1'b0);
    wr(A_CMD, 32'h10);
    idle;
    repeat (12) @(posedge hclk);
    drain(2);
    repeat (3) @(posedge hclk);
    chk("stream 2", fifo_not_empty, 32'h1);
    drain(1);
    repeat (3) @(posedge hclk);
    chk("stream 3", fifo_not_empty, 32'h0);
    wr(A_CTRL, 32'h0);
    wr(A_IVAL, 32'h0);
    wr(A_CNT, 32'h101);
    wr(A_CMD, 32'h4);
    wr(A_CMD, 32'h1);
    idle;
    repeat (12) @(posedge hclk);
    rc("overflow", A_STAT, 32'h7);
    drain(128);
    repeat (3) @(posedge hclk);
    chk("half at 128", fifo_half_full, 32'h1);
    drain(1);
    repeat (3) @(posedge hclk);
    chk("below half", fifo_half_full, 32'h0);
    rc("overflow held", A_STAT, 32'h5);
    wr(A_CMD, 32'h8);
    rc("overflow clear", A_STAT, 32'h1);
    drain(127);
    repeat (3) @(posedge hclk);
    chk("drained", fifo_not_empty, 32'h0);
    wr(A_CTRL, 32'h200);
    sync_bus <= 3'h5;
    repeat (3) @(posedge hclk);
    sync_bus <= 3'h7;
    repeat (20) @(posedge hclk);
    rc("sync convert", A_DATA, 32'h0c65);
    wr(A_CTRL, 32'h6);
    wr(A_GAP, 32'h2);
    wr(A_CNT, 32'h4);
    wr(A_CMD, 32'h1);
    k = 0;
    for (int c = 0; c < 30; c++) begin
      @(posedge hclk);
      if (conversion_scan_pulse === 1'b1 && k < 4) begin
        pt[k] = c;
        k++;
      end
    end
    chk("gap pulses", k, 32'h4);
    chk("gap run", pt[1] - pt[0], 32'h1);
    chk("gap wait", pt[2] - pt[1], 32'h3);
    chk("gap resume", pt[3] - pt[2], 32'h1);
    for (int i = 0; i < 4; i++) rc("interval", A_DATA, i[0] ? 32'h2a5 : 32'hc65);
    end_sim;
  end
endmodule
